// >>> common/icc_defines.svh
`ifndef ICC_DEFINES_SVH
`define ICC_DEFINES_SVH

// register byte offsets
`define ICC_OFS_CTRL 8'h00
`define ICC_OFS_BUF 8'h04
`define ICC_OFS_STAT 8'h08
`define ICC_OFS_MASK 8'h0C
`define ICC_ADDR_W 8

// control register fields
`define ICC_B_STOPIDLE 13
`define ICC_B_TSEL 7
`define ICC_B_CPI_HI 6
`define ICC_B_CPI_LO 5
`define ICC_B_OVF 4
`define ICC_B_BNE 3
`define ICC_B_MODE_HI 2
`define ICC_B_MODE_LO 0
`define ICC_CTRL_RESET 16'h0000

// capture mode codes
`define ICC_M_OFF 3'h0
`define ICC_M_EDGE 3'h1
`define ICC_M_FALL 3'h2
`define ICC_M_RISE 3'h3
`define ICC_M_RISE4 3'h4
`define ICC_M_RISE16 3'h5
`define ICC_M_UNUSED 3'h6
`define ICC_M_WAKE 3'h7

// prescaler terminal counts
`define ICC_PRE4_LAST 4'h3
`define ICC_PRE16_LAST 4'hF

// interrupt status / mask bits
`define ICC_S_CAP 0
`define ICC_S_OVF 1
`define ICC_S_WAKE 2
`define ICC_STAT_W 3
`define ICC_STAT_RESET 3'h0

// buffer geometry
`define ICC_DEPTH 4
`define ICC_PTR_W 2
`define ICC_CNT_W 3

`endif

// >>> common/icc_pkg.sv
package icc_pkg;

	typedef struct packed {
		logic captureStopInIdle;
		logic captureTimerSelect;
		logic [1:0] capturesPerInterrupt;
		logic [2:0] captureModeSelect;
	} icc_ctrl_type;

	typedef struct packed {
		logic valid;
		logic [15:0] value;
	} icc_capture_type;

	typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_RDWAIT} icc_bus_state_type;

endpackage : icc_pkg

// >>> rtl/icc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
`include "icc_defines.svh"

module icc_fifo (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire icc_pkg::icc_capture_type push,
	input wire logic pop,
	output logic [15:0] readData,
	output logic empty,
	output logic full
);
	import icc_pkg::*;

	logic [15:0] mem [`ICC_DEPTH];
	logic [`ICC_PTR_W-1:0] wrPtr;
	logic [`ICC_PTR_W-1:0] rdPtr;
	logic [`ICC_CNT_W-1:0] count;
	logic [`ICC_PTR_W-1:0] next_rdPtr;

	assign empty = (count == `ICC_CNT_W'(0));
	assign full = (count == `ICC_CNT_W'(`ICC_DEPTH));
	assign next_rdPtr = (pop && !empty) ? rdPtr + `ICC_PTR_W'(1) : rdPtr;

	always_ff @(posedge clk_sys) begin
		if (push.valid && !full) begin
			mem[wrPtr] <= push.value;
		end
	end

	// bypass so a word pushed into the head slot is readable at once
	always_ff @(posedge clk_sys) begin
		if (push.valid && !full && next_rdPtr == wrPtr) begin
			readData <= push.value;
		end else begin
			readData <= mem[next_rdPtr];
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (push.valid && !full) begin
				wrPtr <= wrPtr + `ICC_PTR_W'(1);
			end
			rdPtr <= next_rdPtr;
			count <= count + `ICC_CNT_W'(push.valid && !full) - `ICC_CNT_W'(pop && !empty);
		end
	end

endmodule : icc_fifo
`default_nettype wire

// >>> rtl/icc_channel.sv
// Behaviour
// - timer select 1 takes second timer, 0 third
// - interrupt after 1, 2, 3 or 4 captures
// - overflow flag bit 4, read-only, cleared only while mode is 000
// - bit 3 set while buffer holds words
// - mode 111: rising-edge wake interrupt in Sleep/Idle
// - mode 110 captures nothing, but unlike mode 000 it keeps the overflow flag and interrupt count
// - capture stores full 16-bit timer value
// - four-word first-in first-out capture buffer
// - falling, rising, both, 4th, 16th rising edges
// - stop-in-idle bit halts capture during Idle; the mode 111 wake interrupt still fires
`timescale 1ns/1ps
`default_nettype none
`include "icc_defines.svh"

module icc_channel (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [15:0] second_timer_count,
	input wire logic [15:0] third_timer_count,
	input wire logic capture_input_pin,
	input wire logic cpuIdle,
	input wire logic cpuSleep,
	output logic irq
);
	import icc_pkg::*;

	icc_ctrl_type ctrl;
	icc_bus_state_type busState;
	icc_capture_type pushReq;
	logic [`ICC_ADDR_W-1:0] addrReg;
	logic [`ICC_STAT_W-1:0] status;
	logic [`ICC_STAT_W-1:0] mask;
	logic [`ICC_STAT_W-1:0] next_status;
	logic [`ICC_STAT_W-1:0] statSet;
	logic [`ICC_STAT_W-1:0] statClr;
	logic overflowFlag;
	logic pinPrev;
	logic [3:0] prescale;
	logic [1:0] irqCount;
	logic [15:0] fifoReadData;
	logic [15:0] selTimer;
	logic fifoEmpty;
	logic fifoFull;
	logic rise;
	logic fall;
	logic active;
	logic capEvt;
	logic capIrq;
	logic wakeEvt;
	logic ovfEvt;
	logic wrEn;
	logic rdDone;
	logic pop;
	logic [31:0] readMux;

	function automatic logic isReg(input logic [`ICC_ADDR_W-1:0] a,
		input logic [`ICC_ADDR_W-1:0] ofs);
		isReg = (a == ofs);
	endfunction : isReg

	// ---------------- bus slave ----------------
	assign wrEn = (busState == BUS_WRITE);
	assign rdDone = (busState == BUS_RDWAIT);
	assign pop = rdDone && isReg(addrReg, `ICC_OFS_BUF) && !fifoEmpty;

	// reads take one wait state so hrdata can come from a flop
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			busState <= BUS_IDLE;
			addrReg <= '0;
			hreadyout <= 1'b1;
			hrdata <= 32'h0000_0000;
		end else if (hsel && htrans[1] && hready) begin
			addrReg <= haddr[`ICC_ADDR_W-1:0];
			busState <= hwrite ? BUS_WRITE : BUS_RDWAIT;
			hreadyout <= hwrite;
		end else if (rdDone) begin
			hrdata <= readMux;
			hreadyout <= 1'b1;
			busState <= BUS_IDLE;
		end else begin
			busState <= BUS_IDLE;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end

	// unmapped offsets read zero and ignore writes
	always_comb begin
		readMux = 32'h0000_0000;
		if (isReg(addrReg, `ICC_OFS_CTRL)) begin
			readMux[`ICC_B_STOPIDLE] = ctrl.captureStopInIdle;
			readMux[`ICC_B_TSEL] = ctrl.captureTimerSelect;
			readMux[`ICC_B_CPI_HI:`ICC_B_CPI_LO] = ctrl.capturesPerInterrupt;
			readMux[`ICC_B_OVF] = overflowFlag;
			readMux[`ICC_B_BNE] = !fifoEmpty;
			readMux[`ICC_B_MODE_HI:`ICC_B_MODE_LO] = ctrl.captureModeSelect;
		end else if (isReg(addrReg, `ICC_OFS_BUF)) begin
			readMux[15:0] = fifoReadData;
		end else if (isReg(addrReg, `ICC_OFS_STAT)) begin
			readMux[`ICC_STAT_W-1:0] = status;
		end else if (isReg(addrReg, `ICC_OFS_MASK)) begin
			readMux[`ICC_STAT_W-1:0] = mask;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ctrl <= icc_ctrl_type'(7'h00);
			mask <= `ICC_STAT_RESET;
		end else if (wrEn && isReg(addrReg, `ICC_OFS_CTRL)) begin
			// overflow and buffer-status bits are read-only
			ctrl.captureStopInIdle <= hwdata[`ICC_B_STOPIDLE];
			ctrl.captureTimerSelect <= hwdata[`ICC_B_TSEL];
			ctrl.capturesPerInterrupt <= hwdata[`ICC_B_CPI_HI:`ICC_B_CPI_LO];
			ctrl.captureModeSelect <= hwdata[`ICC_B_MODE_HI:`ICC_B_MODE_LO];
		end else if (wrEn && isReg(addrReg, `ICC_OFS_MASK)) begin
			mask <= hwdata[`ICC_STAT_W-1:0];
		end
	end

	// ---------------- edge detection and capture ----------------
	assign rise = capture_input_pin && !pinPrev;
	assign fall = !capture_input_pin && pinPrev;
	assign active = !(ctrl.captureStopInIdle && cpuIdle);
	assign selTimer = ctrl.captureTimerSelect ? second_timer_count : third_timer_count;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pinPrev <= 1'b0;
		end else begin
			pinPrev <= capture_input_pin;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			prescale <= 4'h0;
		end else if (ctrl.captureModeSelect != `ICC_M_RISE4
			&& ctrl.captureModeSelect != `ICC_M_RISE16) begin
			prescale <= 4'h0;
		end else if (rise && active) begin
			if (capEvt) begin
				prescale <= 4'h0;
			end else begin
				prescale <= prescale + 4'h1;
			end
		end
	end

	always_comb begin
		capEvt = 1'b0;
		case (ctrl.captureModeSelect)
			`ICC_M_EDGE: capEvt = rise || fall;
			`ICC_M_FALL: capEvt = fall;
			`ICC_M_RISE: capEvt = rise;
			`ICC_M_RISE4: capEvt = rise && prescale == `ICC_PRE4_LAST;
			`ICC_M_RISE16: capEvt = rise && prescale == `ICC_PRE16_LAST;
			default: capEvt = 1'b0;
		endcase
		capEvt = capEvt && active;
	end

	assign pushReq.valid = capEvt && !fifoFull;
	assign pushReq.value = selTimer;
	assign ovfEvt = capEvt && fifoFull;

	// a full buffer drops the new value and flags the loss
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			overflowFlag <= 1'b0;
		end else if (ovfEvt) begin
			overflowFlag <= 1'b1;
		end else if (ctrl.captureModeSelect == `ICC_M_OFF) begin
			overflowFlag <= 1'b0;
		end
	end

	icc_fifo icc_fifo_inst (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.push(pushReq),
		.pop(pop),
		.readData(fifoReadData),
		.empty(fifoEmpty),
		.full(fifoFull)
	);

	// ---------------- interrupts ----------------
	assign capIrq = capEvt && (ctrl.captureModeSelect == `ICC_M_EDGE
		|| irqCount == ctrl.capturesPerInterrupt);
	assign wakeEvt = ctrl.captureModeSelect == `ICC_M_WAKE && (cpuSleep || cpuIdle) && rise;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			irqCount <= 2'h0;
		end else if (ctrl.captureModeSelect == `ICC_M_OFF || capIrq) begin
			irqCount <= 2'h0;
		end else if (capEvt) begin
			irqCount <= irqCount + 2'h1;
		end
	end

	always_comb begin
		statSet = '0;
		statSet[`ICC_S_CAP] = capIrq;
		statSet[`ICC_S_OVF] = ovfEvt;
		statSet[`ICC_S_WAKE] = wakeEvt;
		statClr = (wrEn && isReg(addrReg, `ICC_OFS_STAT)) ? hwdata[`ICC_STAT_W-1:0] : '0;
		// a new event outlives a clear in the same cycle
		next_status = (status & ~statClr) | statSet;
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			status <= `ICC_STAT_RESET;
			irq <= 1'b0;
		end else begin
			status <= next_status;
			irq <= |(next_status & mask);
		end
	end

	// ---------------- checks ----------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	// shadow fill level kept apart from the buffer's own counter
	logic [`ICC_CNT_W-1:0] fillLevel;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			fillLevel <= '0;
		end else begin
			fillLevel <= fillLevel + `ICC_CNT_W'(pushReq.valid) - `ICC_CNT_W'(pop);
		end
	end

	sequence seq_wake_edge;
		ctrl.captureModeSelect == `ICC_M_WAKE && (cpuSleep || cpuIdle) && rise;
	endsequence

	sequence seq_pre16_hit;
		ctrl.captureModeSelect == `ICC_M_RISE16 && active && rise
			&& prescale == `ICC_PRE16_LAST;
	endsequence

	chk_timer_select: assert property (
		(pushReq.valid && fifoEmpty && !pop) |=> fifoReadData == $past(selTimer))
		else $error("captured value is not the selected timer");

	chk_irq_count: assert property (
		capIrq |=> status[`ICC_S_CAP] && irqCount == 2'h0)
		else $error("capture interrupt not raised at count");

	chk_ovf_sticky: assert property (
		(ovfEvt ##1 ctrl.captureModeSelect != `ICC_M_OFF) |-> overflowFlag)
		else $error("overflow flag not held");

	chk_bne_status: assert property (
		(rdDone && isReg(addrReg, `ICC_OFS_CTRL)) |=> hrdata[`ICC_B_BNE] == $past(!fifoEmpty))
		else $error("buffer status bit wrong");

	chk_wake_only: assert property (
		seq_wake_edge |=> status[`ICC_S_WAKE] && !$past(capEvt))
		else $error("wake edge mishandled");

	chk_unused_off: assert property (
		ctrl.captureModeSelect == `ICC_M_UNUSED |-> !capEvt && !pushReq.valid)
		else $error("unused mode captured");

	chk_fifo_depth: assert property (
		(pushReq.valid && !pop && fillLevel == `ICC_CNT_W'(`ICC_DEPTH - 1)) |=> fifoFull)
		else $error("buffer not full after fourth word");

	chk_fifo_bound: assert property (
		fifoFull |-> fillLevel == `ICC_CNT_W'(`ICC_DEPTH) && !pushReq.valid)
		else $error("full buffer does not hold exactly four words");

	chk_pre16_hit: assert property (
		seq_pre16_hit |-> capEvt ##1 prescale == 4'h0)
		else $error("sixteenth rising edge not captured");

	chk_idle_halt: assert property (
		(ctrl.captureStopInIdle && cpuIdle) |-> !capEvt)
		else $error("capture while halted in idle");

	chk_every_edge: assert property (
		(ctrl.captureModeSelect == `ICC_M_EDGE && active && (rise || fall)) |-> capIrq)
		else $error("every-edge mode missed interrupt");

endmodule : icc_channel
`default_nettype wire

// >>> test/icc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module icc_pin_model (
	input wire logic clk_sys,
	output logic pinLevel
);
	initial begin
		pinLevel = 1'b0;
	end

	// one change per two clocks, so the channel sees every level for a full cycle
	task automatic toggle(input int n);
		repeat (n) begin
			@(posedge clk_sys);
			pinLevel <= ~pinLevel;
			@(posedge clk_sys);
		end
	endtask : toggle
endmodule : icc_pin_model

`default_nettype wire

// >>> test/test_input_capture_channel_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "icc_defines.svh"
`define CHK(a, e) begin nTests++; if ((a) !== (e)) begin badCount++; $display("[ERR] %0t got %h want %h", $time, a, e); end end

module test_input_capture_channel_control;
	import icc_pkg::*;
	logic clk_sys, resetn, hsel, hwrite, hreadyout, hresp, cpuIdle, cpuSleep, irq, pin;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [15:0] secondCount, thirdCount;
	int badCount = 0;
	int nTests = 0;
	logic [2:0] modeTab [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
	int togTab [7] = '{8, 1, 2, 1, 7, 31, 8};
	logic [31:0] bneTab [7] = '{32'h0000_0000, 32'h0000_0008, 32'h0000_0008, 32'h0000_0008,
		32'h0000_0008, 32'h0000_0008, 32'h0000_0000};

	icc_pin_model icc_pin_model_inst (.clk_sys(clk_sys), .pinLevel(pin));

	icc_channel icc_channel_inst (
		.clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.second_timer_count(secondCount), .third_timer_count(thirdCount),
		.capture_input_pin(pin), .cpuIdle(cpuIdle), .cpuSleep(cpuSleep), .irq(irq)
	);

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= {16'h0000, d};
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		xfer(1'b1, a, d);
	endtask : wr

	task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		xfer(1'b0, a, 16'h0000);
		`CHK(q & m, e)
	endtask : rdChk

	task automatic tog(input int n);
		icc_pin_model_inst.toggle(n);
	endtask : tog

	// disable, drain, clear status, park pin low while nothing listens
	task automatic clean;
		wr(`ICC_OFS_CTRL, 16'h0000);
		repeat (4) xfer(1'b0, `ICC_OFS_BUF, 16'h0000);
		wr(`ICC_OFS_STAT, 16'h0007);
		if (pin) tog(1);
	endtask : clean

	task automatic testReset;
		rdChk(`ICC_OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
		rdChk(`ICC_OFS_STAT, 32'hFFFF_FFFF, 32'h0000_0000);
		rdChk(8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
		`CHK(irq, 1'b0)
		`CHK(hresp, 1'b0)
	endtask : testReset

	task automatic testSelect;
		clean();
		secondCount <= 16'hA5C3;
		thirdCount <= 16'h5A3C;
		wr(`ICC_OFS_CTRL, 16'h0083);
		tog(1);
		rdChk(`ICC_OFS_CTRL, 32'h0000_0008, 32'h0000_0008);
		rdChk(`ICC_OFS_STAT, 32'h0000_0001, 32'h0000_0001);
		`CHK(irq, 1'b0)
		rdChk(`ICC_OFS_BUF, 32'hFFFF_FFFF, 32'h0000_A5C3);
		rdChk(`ICC_OFS_CTRL, 32'h0000_0008, 32'h0000_0000);
		wr(`ICC_OFS_STAT, 16'h0001);
		rdChk(`ICC_OFS_STAT, 32'h0000_0001, 32'h0000_0000);
		wr(`ICC_OFS_CTRL, 16'h0003);
		tog(2);
		rdChk(`ICC_OFS_BUF, 32'hFFFF_FFFF, 32'h0000_5A3C);
	endtask : testSelect

	task automatic testOverflow;
		clean();
		wr(`ICC_OFS_CTRL, 16'h0003);
		for (int i = 1; i <= 5; i++) begin
			thirdCount <= 16'(i);
			tog(2);
		end
		rdChk(`ICC_OFS_CTRL, 32'h0000_0010, 32'h0000_0010);
		wr(`ICC_OFS_CTRL, 16'h0003);
		rdChk(`ICC_OFS_CTRL, 32'h0000_0010, 32'h0000_0010);
		rdChk(`ICC_OFS_STAT, 32'h0000_0002, 32'h0000_0002);
		for (int i = 1; i <= 4; i++) begin
			rdChk(`ICC_OFS_BUF, 32'hFFFF_FFFF, i);
		end
		rdChk(`ICC_OFS_CTRL, 32'h0000_0008, 32'h0000_0000);
		wr(`ICC_OFS_CTRL, 16'h0000);
		rdChk(`ICC_OFS_CTRL, 32'h0000_0010, 32'h0000_0000);
	endtask : testOverflow

	task automatic testPerInterrupt;
		for (int c = 0; c < 4; c++) begin
			clean();
			wr(`ICC_OFS_MASK, 16'h0001);
			wr(`ICC_OFS_CTRL, 16'(c << 5) | 16'h0003);
			for (int k = 1; k <= c + 1; k++) begin
				tog(2);
				rdChk(`ICC_OFS_STAT, 32'h0000_0001, 32'(k == c + 1));
			end
			`CHK(irq, 1'b1)
		end
		wr(`ICC_OFS_MASK, 16'h0000);
	endtask : testPerInterrupt

	// last toggle of each entry is the one that must (or must not) capture
	task automatic testModes;
		for (int m = 0; m < 7; m++) begin
			clean();
			wr(`ICC_OFS_CTRL, {13'h0000, modeTab[m]});
			tog(togTab[m] - 1);
			rdChk(`ICC_OFS_CTRL, 32'h0000_0008, 32'h0000_0000);
			tog(1);
			rdChk(`ICC_OFS_CTRL, 32'h0000_0008, bneTab[m]);
		end
	endtask : testModes

	task automatic testWakeIdle;
		clean();
		wr(`ICC_OFS_MASK, 16'h0004);
		wr(`ICC_OFS_CTRL, 16'h2007);
		tog(2);
		rdChk(`ICC_OFS_STAT, 32'h0000_0007, 32'h0000_0000);
		cpuIdle <= 1'b1;
		tog(1);
		rdChk(`ICC_OFS_STAT, 32'h0000_0007, 32'h0000_0004);
		`CHK(irq, 1'b1)
		rdChk(`ICC_OFS_CTRL, 32'h0000_0008, 32'h0000_0000);
		wr(`ICC_OFS_STAT, 16'h0004);
		tog(1);
		rdChk(`ICC_OFS_STAT, 32'h0000_0007, 32'h0000_0000);
		`CHK(irq, 1'b0)
		cpuIdle <= 1'b0;
		cpuSleep <= 1'b1;
		tog(1);
		rdChk(`ICC_OFS_STAT, 32'h0000_0007, 32'h0000_0004);
		`CHK(irq, 1'b1)
		cpuSleep <= 1'b0;
		cpuIdle <= 1'b1;
		clean();
		wr(`ICC_OFS_CTRL, 16'h2003);
		tog(2);
		rdChk(`ICC_OFS_CTRL, 32'h0000_0008, 32'h0000_0000);
		wr(`ICC_OFS_CTRL, 16'h0003);
		tog(1);
		rdChk(`ICC_OFS_CTRL, 32'h0000_0008, 32'h0000_0008);
		cpuIdle <= 1'b0;
		wr(`ICC_OFS_MASK, 16'h0000);
	endtask : testWakeIdle

	task automatic printVerdict;
		$display("comparisons %0d mismatches %0d", nTests, badCount);
		if (badCount == 0 && nTests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : printVerdict

	initial begin
		resetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		secondCount = 16'h0000;
		thirdCount = 16'h0000;
		cpuIdle = 1'b0;
		cpuSleep = 1'b0;
		repeat (4) @(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys);
		testReset();
		testSelect();
		testOverflow();
		testPerInterrupt();
		testModes();
		testWakeIdle();
		printVerdict();
	end

	// whole sequence needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk_sys);
		badCount++;
		printVerdict();
	end
endmodule : test_input_capture_channel_control

`default_nettype wire
